// ===== rtl/klt_pkg.sv
package klt_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam int STRB_W = DATA_W / 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_AN_OVERRIDE = 10'h0c0;
  localparam logic [IDX_W-1:0] IDX_AN_MASTER_LANE_SELECT = 10'h0cc;
  localparam logic [IDX_W-1:0] IDX_COEF_OVERRIDE = 10'h0d0;
  localparam logic [IDX_W-1:0] IDX_LANE_TRAINING_COMMANDS = 10'h0d1;
  localparam logic [IDX_W-1:0] IDX_FRAME_LOCK_ERROR_STATUS = 10'h0d2;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h0f8;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0f9;

  // Field positions
  localparam int AN_OVR_EN_BIT = 6;
  localparam int AN_SEL_LSB = 0;
  localparam int NUM_LANES = 4;
  localparam int PARTNER_EN_BIT = 16;
  localparam int LOCAL_EN_BIT = 17;
  localparam int CMD_LANES = 3;
  localparam int RESTART_LSB = 1;
  localparam int TX_NEW_LSB = 5;
  localparam int RX_NEW_LSB = 9;
  localparam int COEF_W = 8;
  localparam int FLE_W = 8;

  // Reset values
  localparam logic AN_OVR_EN_RST = 1'b0;
  localparam logic [NUM_LANES-1:0] AN_SEL_RST = 4'h0;
  localparam logic PARTNER_EN_RST = 1'b0;
  localparam logic LOCAL_EN_RST = 1'b0;
  localparam logic [NUM_LANES-1:0] IRQ_MASK_RST = 4'h0;

  // Write and read responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [DATA_W-1:0] strb_mask(
      input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < STRB_W; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  function automatic logic [DATA_W-1:0] merge_word(
      input logic [DATA_W-1:0] old_w, input logic [DATA_W-1:0] new_w,
      input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] m;
    m = strb_mask(strb);
    return (old_w & ~m) | (new_w & m);
  endfunction

endpackage

// ===== rtl/klt_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface klt_reg_if;
  import klt_pkg::*;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic wr_ok;
  logic [IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;

  modport slave (output wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                 input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                output wr_ok, rd_data, rd_ok);
  modport snoop (input wr_en, wr_idx, wr_data, wr_strb);
endinterface
`default_nettype wire

// ===== rtl/klt_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module klt_axil_slave
  import klt_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic [STRB_W-1:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  klt_reg_if.slave bus
);

  logic [ADDR_W-1:0] aw_addr;

  ////////////////////////////////////////////////////////////////////////
  // Address and data are held apart so either may arrive first
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      awready_out <= 1'b1;
      aw_addr <= '0;
    end else if (awvalid_in && awready_out) begin
      awready_out <= 1'b0;
      aw_addr <= awaddr_in;
    end else if (bvalid_out && bready_in) begin
      awready_out <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      wready_out <= 1'b1;
      bus.wr_data <= '0;
      bus.wr_strb <= '0;
    end else if (wvalid_in && wready_out) begin
      wready_out <= 1'b0;
      bus.wr_data <= wdata_in;
      bus.wr_strb <= wstrb_in;
    end else if (bvalid_out && bready_in) begin
      wready_out <= 1'b1;
    end
  end

  // One-cycle write pulse once both halves are held
  assign bus.wr_en = !awready_out && !wready_out && !bvalid_out;
  assign bus.wr_idx = aw_addr[ADDR_W-1:2];

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      bvalid_out <= 1'b0;
      bresp_out <= RESP_OKAY;
    end else if (bus.wr_en) begin
      bvalid_out <= 1'b1;
      bresp_out <= bus.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready_in) begin
      bvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data is captured at the address handshake
  assign bus.rd_idx = araddr_in[ADDR_W-1:2];

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rdata_out <= '0;
      rresp_out <= RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b1;
      rdata_out <= bus.rd_ok ? bus.rd_data : '0;
      rresp_out <= bus.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_out && rready_in) begin
      rvalid_out <= 1'b0;
      arready_out <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/klt_lane_cmd.sv
`timescale 1ns/1ps
`default_nettype none
module klt_lane_cmd
  import klt_pkg::*;
#(
  parameter int LANES = CMD_LANES
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  klt_reg_if.snoop bus,
  input wire logic partner_en_in,
  input wire logic local_en_in,
  input wire logic [LANES*COEF_W-1:0] local_coef_in,
  output logic [LANES-1:0] restart_out,
  output logic [LANES-1:0] tx_new_out,
  output logic [LANES-1:0] rx_new_out,
  output logic [LANES*COEF_W-1:0] coef_out
);

  logic cmd_wr;
  logic [DATA_W-1:0] cmd_data;

  // Unstrobed byte lanes carry no command
  assign cmd_wr = bus.wr_en && (bus.wr_idx == IDX_LANE_TRAINING_COMMANDS);
  assign cmd_data = bus.wr_data & strb_mask(bus.wr_strb);

  ////////////////////////////////////////////////////////////////////////
  // Commands are single pulses; nothing is stored, so they read back 0
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      restart_out <= '0;
    end else if (cmd_wr) begin
      restart_out <= cmd_data[RESTART_LSB +: LANES];
    end else begin
      restart_out <= '0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      tx_new_out <= '0;
    end else if (cmd_wr && partner_en_in) begin
      tx_new_out <= cmd_data[TX_NEW_LSB +: LANES];
    end else begin
      tx_new_out <= '0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      rx_new_out <= '0;
    end else if (cmd_wr && local_en_in) begin
      rx_new_out <= cmd_data[RX_NEW_LSB +: LANES];
    end else begin
      rx_new_out <= '0;
    end
  end

  // Coefficients latched with the pulse so they stay put afterwards
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      coef_out <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (cmd_wr && local_en_in && cmd_data[RX_NEW_LSB + i]) begin
          coef_out[i*COEF_W +: COEF_W] <=
              local_coef_in[i*COEF_W +: COEF_W];
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== rtl/klt_lane_training_overrides.sv
`timescale 1ns/1ps
`default_nettype none
module klt_lane_training_overrides
  import klt_pkg::*;
#(
  parameter int AN_MASTER_LANE = 0
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] s_axil_awaddr_in,
  input wire logic s_axil_awvalid_in,
  output logic s_axil_awready_out,
  input wire logic [DATA_W-1:0] s_axil_wdata_in,
  input wire logic [STRB_W-1:0] s_axil_wstrb_in,
  input wire logic s_axil_wvalid_in,
  output logic s_axil_wready_out,
  output logic [1:0] s_axil_bresp_out,
  output logic s_axil_bvalid_out,
  input wire logic s_axil_bready_in,
  input wire logic [ADDR_W-1:0] s_axil_araddr_in,
  input wire logic s_axil_arvalid_in,
  output logic s_axil_arready_out,
  output logic [DATA_W-1:0] s_axil_rdata_out,
  output logic [1:0] s_axil_rresp_out,
  output logic s_axil_rvalid_out,
  input wire logic s_axil_rready_in,
  input wire logic [NUM_LANES*FLE_W-1:0] frame_lock_err_in,
  input wire logic [CMD_LANES*COEF_W-1:0] local_coef_in,
  output logic [NUM_LANES-1:0] an_master_lane_out,
  output logic [CMD_LANES-1:0] restart_training_out,
  output logic [CMD_LANES-1:0] partner_coef_new_out,
  output logic [CMD_LANES-1:0] local_coef_new_out,
  output logic [CMD_LANES*COEF_W-1:0] local_coef_out,
  output logic irq_out
);

  klt_reg_if bus ();

  logic an_master_override_en;
  logic [NUM_LANES-1:0] an_master_lane_select;
  logic partner_coef_override_en;
  logic local_coef_override_en;
  logic [NUM_LANES*FLE_W-1:0] frame_lock_error_status;
  logic [NUM_LANES-1:0] lane_err;
  logic [NUM_LANES-1:0] lane_err_q;
  logic [NUM_LANES-1:0] irq_status;
  logic [NUM_LANES-1:0] irq_mask;
  logic [NUM_LANES-1:0] next_irq_status;
  logic [NUM_LANES-1:0] next_irq_mask;
  logic [NUM_LANES-1:0] irq_clear;
  logic [DATA_W-1:0] word_an;
  logic [DATA_W-1:0] word_sel;
  logic [DATA_W-1:0] word_coef;
  logic [DATA_W-1:0] word_mask;
  logic [DATA_W-1:0] new_word;

  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    return idx == IDX_AN_OVERRIDE || idx == IDX_AN_MASTER_LANE_SELECT ||
           idx == IDX_COEF_OVERRIDE || idx == IDX_LANE_TRAINING_COMMANDS ||
           idx == IDX_FRAME_LOCK_ERROR_STATUS || idx == IDX_IRQ_STATUS ||
           idx == IDX_IRQ_MASK;
  endfunction

  function automatic logic [NUM_LANES-1:0] lane_onehot(input int lane);
    return NUM_LANES'(1) << lane;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus slave and command pulses
  klt_axil_slave u_slave (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .awaddr_in(s_axil_awaddr_in),
    .awvalid_in(s_axil_awvalid_in),
    .awready_out(s_axil_awready_out),
    .wdata_in(s_axil_wdata_in),
    .wstrb_in(s_axil_wstrb_in),
    .wvalid_in(s_axil_wvalid_in),
    .wready_out(s_axil_wready_out),
    .bresp_out(s_axil_bresp_out),
    .bvalid_out(s_axil_bvalid_out),
    .bready_in(s_axil_bready_in),
    .araddr_in(s_axil_araddr_in),
    .arvalid_in(s_axil_arvalid_in),
    .arready_out(s_axil_arready_out),
    .rdata_out(s_axil_rdata_out),
    .rresp_out(s_axil_rresp_out),
    .rvalid_out(s_axil_rvalid_out),
    .rready_in(s_axil_rready_in),
    .bus(bus.slave)
  );

  klt_lane_cmd #(
    .LANES(CMD_LANES)
  ) u_cmd (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .bus(bus.snoop),
    .partner_en_in(partner_coef_override_en),
    .local_en_in(local_coef_override_en),
    .local_coef_in(local_coef_in),
    .restart_out(restart_training_out),
    .tx_new_out(partner_coef_new_out),
    .rx_new_out(local_coef_new_out),
    .coef_out(local_coef_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Current register words, used for readback and for byte merging
  always_comb begin
    word_an = '0;
    word_an[AN_OVR_EN_BIT] = an_master_override_en;
    word_sel = '0;
    word_sel[AN_SEL_LSB +: NUM_LANES] = an_master_lane_select;
    word_coef = '0;
    word_coef[PARTNER_EN_BIT] = partner_coef_override_en;
    word_coef[LOCAL_EN_BIT] = local_coef_override_en;
    word_mask = '0;
    word_mask[NUM_LANES-1:0] = irq_mask;
  end

  always_comb begin
    bus.rd_data = '0;
    case (bus.rd_idx)
      IDX_AN_OVERRIDE: bus.rd_data = word_an;
      IDX_AN_MASTER_LANE_SELECT: bus.rd_data = word_sel;
      IDX_COEF_OVERRIDE: bus.rd_data = word_coef;
      IDX_LANE_TRAINING_COMMANDS: bus.rd_data = '0;
      IDX_FRAME_LOCK_ERROR_STATUS: bus.rd_data = frame_lock_error_status;
      IDX_IRQ_STATUS: bus.rd_data[NUM_LANES-1:0] = irq_status;
      IDX_IRQ_MASK: bus.rd_data = word_mask;
      default: bus.rd_data = '0;
    endcase
  end

  assign bus.rd_ok = idx_mapped(bus.rd_idx);
  // Writes to the status word are accepted and dropped
  assign bus.wr_ok = idx_mapped(bus.wr_idx);

  always_comb begin
    case (bus.wr_idx)
      IDX_AN_OVERRIDE: new_word = merge_word(word_an, bus.wr_data,
                                             bus.wr_strb);
      IDX_AN_MASTER_LANE_SELECT: new_word = merge_word(word_sel,
                                     bus.wr_data, bus.wr_strb);
      IDX_COEF_OVERRIDE: new_word = merge_word(word_coef, bus.wr_data,
                                               bus.wr_strb);
      IDX_IRQ_MASK: new_word = merge_word(word_mask, bus.wr_data,
                                          bus.wr_strb);
      default: new_word = bus.wr_data & strb_mask(bus.wr_strb);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Master lane override
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      an_master_override_en <= AN_OVR_EN_RST;
    end else if (bus.wr_en && bus.wr_idx == IDX_AN_OVERRIDE) begin
      an_master_override_en <= new_word[AN_OVR_EN_BIT];
    end
  end

  // Non one-hot codes pass unchanged; keeping them out is up to software
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      an_master_lane_select <= AN_SEL_RST;
    end else if (bus.wr_en && bus.wr_idx == IDX_AN_MASTER_LANE_SELECT) begin
      an_master_lane_select <= new_word[AN_SEL_LSB +: NUM_LANES];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      an_master_lane_out <= lane_onehot(AN_MASTER_LANE);
    end else if (an_master_override_en) begin
      an_master_lane_out <= an_master_lane_select;
    end else begin
      an_master_lane_out <= lane_onehot(AN_MASTER_LANE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Coefficient override enables
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      partner_coef_override_en <= PARTNER_EN_RST;
      local_coef_override_en <= LOCAL_EN_RST;
    end else if (bus.wr_en && bus.wr_idx == IDX_COEF_OVERRIDE) begin
      partner_coef_override_en <= new_word[PARTNER_EN_BIT];
      local_coef_override_en <= new_word[LOCAL_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame-lock status, sampled every cycle so reads see a stable word
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      frame_lock_error_status <= '0;
      lane_err_q <= '0;
    end else begin
      frame_lock_error_status <= frame_lock_err_in;
      lane_err_q <= lane_err;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_LANES; i++) begin
      lane_err[i] = |frame_lock_error_status[i*FLE_W +: FLE_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: a new error on a lane wins over a clear in the same cycle
  always_comb begin
    irq_clear = '0;
    if (bus.wr_en && bus.wr_idx == IDX_IRQ_STATUS) begin
      irq_clear = new_word[NUM_LANES-1:0];
    end
    next_irq_status = (irq_status & ~irq_clear) | (lane_err & ~lane_err_q);
    next_irq_mask = irq_mask;
    if (bus.wr_en && bus.wr_idx == IDX_IRQ_MASK) begin
      next_irq_mask = new_word[NUM_LANES-1:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      irq_status <= '0;
      irq_mask <= IRQ_MASK_RST;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  // Built from the next values so the line tracks the unmasked status bits exactly
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(next_irq_status & next_irq_mask);
    end
  end

endmodule
`default_nettype wire

// ===== test/klt_lto_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module klt_lto_asserts
  import klt_pkg::*;
#(
  parameter int AN_MASTER_LANE = 0
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] s_axil_awaddr_in,
  input wire logic s_axil_awvalid_in,
  input wire logic s_axil_awready_out,
  input wire logic [DATA_W-1:0] s_axil_wdata_in,
  input wire logic [STRB_W-1:0] s_axil_wstrb_in,
  input wire logic s_axil_wvalid_in,
  input wire logic s_axil_wready_out,
  input wire logic s_axil_bvalid_out,
  input wire logic [ADDR_W-1:0] s_axil_araddr_in,
  input wire logic s_axil_arvalid_in,
  input wire logic s_axil_arready_out,
  input wire logic [DATA_W-1:0] s_axil_rdata_out,
  input wire logic s_axil_rvalid_out,
  input wire logic [NUM_LANES*FLE_W-1:0] frame_lock_err_in,
  input wire logic [CMD_LANES*COEF_W-1:0] local_coef_in,
  input wire logic [NUM_LANES-1:0] an_master_lane_out,
  input wire logic [CMD_LANES-1:0] restart_training_out,
  input wire logic [CMD_LANES-1:0] partner_coef_new_out,
  input wire logic [CMD_LANES-1:0] local_coef_new_out,
  input wire logic [CMD_LANES*COEF_W-1:0] local_coef_out
);
  logic [IDX_W-1:0] aw_i, ar_i;
  logic [DATA_W-1:0] wd;
  logic [STRB_W-1:0] ws;
  logic an_en, p_en, l_en, cmd, pls, bv;
  logic [NUM_LANES-1:0] sel;
  logic [CMD_LANES*COEF_W-1:0] cmask;
  assign bv = s_axil_bvalid_out;
  assign cmd = aw_i == IDX_LANE_TRAINING_COMMANDS;
  assign pls = |{restart_training_out, partner_coef_new_out,
                 local_coef_new_out};
  assign cmask = {{8{local_coef_new_out[2]}}, {8{local_coef_new_out[1]}},
                  {8{local_coef_new_out[0]}}};
  always_ff @(posedge clock_in) begin
    if (s_axil_awvalid_in && s_axil_awready_out) begin
      aw_i <= s_axil_awaddr_in[ADDR_W-1:2];
    end
    if (s_axil_wvalid_in && s_axil_wready_out) begin
      wd <= s_axil_wdata_in;
      ws <= s_axil_wstrb_in;
    end
    if (s_axil_arvalid_in && s_axil_arready_out) begin
      ar_i <= s_axil_araddr_in[ADDR_W-1:2];
    end
  end
  // Shadow moves on the response edge, so gating sees the old enables
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      an_en <= AN_OVR_EN_RST;
      sel <= AN_SEL_RST;
      p_en <= PARTNER_EN_RST;
      l_en <= LOCAL_EN_RST;
    end else if ($rose(bv)) begin
      if (aw_i == IDX_AN_OVERRIDE && ws[0]) an_en <= wd[6];
      if (aw_i == IDX_AN_MASTER_LANE_SELECT && ws[0]) sel <= wd[3:0];
      if (aw_i == IDX_COEF_OVERRIDE && ws[2]) {l_en, p_en} <= wd[17:16];
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking dc @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);
  property p_an_ovr;
    an_en |-> an_master_lane_out == sel;
  endproperty
  a_an_ovr: assert property (p_an_ovr)
    else $error("master lane differs from select field");
  property p_an_par;
    !an_en |-> an_master_lane_out == (4'h1 << AN_MASTER_LANE);
  endproperty
  a_an_par: assert property (p_an_par)
    else $error("master lane differs from build-time lane");
  property p_restart;
    $rose(bv) && cmd |-> restart_training_out == (ws[0] ? wd[3:1] : 3'h0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart pulse wrong");
  property p_tx;
    $rose(bv) && cmd |->
      partner_coef_new_out == (ws[0] && p_en ? wd[7:5] : 3'h0);
  endproperty
  a_tx: assert property (p_tx)
    else $error("partner coefficient pulse wrong");
  property p_rx;
    $rose(bv) && cmd |->
      local_coef_new_out == (ws[1] && l_en ? wd[11:9] : 3'h0);
  endproperty
  a_rx: assert property (p_rx)
    else $error("local coefficient pulse wrong");
  property p_quiet;
    pls |-> $rose(bv) && cmd;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("command pulse without a command write");
  property p_short;
    pls |=> !pls;
  endproperty
  a_short: assert property (p_short)
    else $error("command pulse longer than one cycle");
  property p_coef;
    local_coef_new_out != 3'h0 |->
      ((local_coef_out ^ $past(local_coef_in)) & cmask) == 24'h0;
  endproperty
  a_coef: assert property (p_coef)
    else $error("local coefficients not loaded with the pulse");
  property p_flock;
    $rose(s_axil_rvalid_out) && ar_i == IDX_FRAME_LOCK_ERROR_STATUS |->
      s_axil_rdata_out == $past(frame_lock_err_in, 2);
  endproperty
  a_flock: assert property (p_flock)
    else $error("frame lock status read wrong");
endmodule
bind klt_lane_training_overrides klt_lto_asserts #(
  .AN_MASTER_LANE(AN_MASTER_LANE)
) u_chk (
  .clock_in(clock_in), .rstn_in(rstn_in),
  .s_axil_awaddr_in(s_axil_awaddr_in),
  .s_axil_awvalid_in(s_axil_awvalid_in),
  .s_axil_awready_out(s_axil_awready_out),
  .s_axil_wdata_in(s_axil_wdata_in), .s_axil_wstrb_in(s_axil_wstrb_in),
  .s_axil_wvalid_in(s_axil_wvalid_in),
  .s_axil_wready_out(s_axil_wready_out),
  .s_axil_bvalid_out(s_axil_bvalid_out),
  .s_axil_araddr_in(s_axil_araddr_in),
  .s_axil_arvalid_in(s_axil_arvalid_in),
  .s_axil_arready_out(s_axil_arready_out),
  .s_axil_rdata_out(s_axil_rdata_out),
  .s_axil_rvalid_out(s_axil_rvalid_out),
  .frame_lock_err_in(frame_lock_err_in), .local_coef_in(local_coef_in),
  .an_master_lane_out(an_master_lane_out),
  .restart_training_out(restart_training_out),
  .partner_coef_new_out(partner_coef_new_out),
  .local_coef_new_out(local_coef_new_out),
  .local_coef_out(local_coef_out)
);
`default_nettype wire

// ===== test/klt_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Lane training side: reports lock errors, offers taps, logs commands
module klt_partner
  import klt_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [CMD_LANES-1:0] restart_in,
  input wire logic [CMD_LANES-1:0] tx_new_in,
  input wire logic [CMD_LANES-1:0] rx_new_in,
  input wire logic [NUM_LANES*FLE_W-1:0] fle_in,
  input wire logic clr_in,
  output logic [NUM_LANES*FLE_W-1:0] fle_out,
  output logic [CMD_LANES*COEF_W-1:0] coef_out,
  output logic [3*CMD_LANES-1:0] seen_out
);
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      fle_out <= 32'h0;
      coef_out <= 24'h0;
    end else begin
      fle_out <= fle_in;
      // Taps move every cycle so a latch on the wrong edge shows up
      coef_out <= coef_out + 24'h1f2e3d;
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rstn_in || clr_in) begin
      seen_out <= 9'h0;
    end else begin
      seen_out <= seen_out | {rx_new_in, tx_new_in, restart_in};
    end
  end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import klt_pkg::*;
;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, clr;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, fle, fle_set, r;
  logic [STRB_W-1:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [CMD_LANES-1:0] rst_p, tx_p, rx_p;
  logic [CMD_LANES*COEF_W-1:0] coef;
  logic [NUM_LANES-1:0] lane;
  logic [8:0] seen;
  logic [33:0] e;
  logic [1:0] qb[$];
  logic [33:0] qr[$];
  int error_cnt, n_checks, cyc;
  klt_lane_training_overrides uut (
    .clock_in(clk), .rstn_in(rstn),
    .s_axil_awaddr_in(awaddr), .s_axil_awvalid_in(awvalid),
    .s_axil_awready_out(awready), .s_axil_wdata_in(wdata),
    .s_axil_wstrb_in(wstrb), .s_axil_wvalid_in(wvalid),
    .s_axil_wready_out(wready), .s_axil_bresp_out(bresp),
    .s_axil_bvalid_out(bvalid), .s_axil_bready_in(bready),
    .s_axil_araddr_in(araddr), .s_axil_arvalid_in(arvalid),
    .s_axil_arready_out(arready), .s_axil_rdata_out(rdata),
    .s_axil_rresp_out(rresp), .s_axil_rvalid_out(rvalid),
    .s_axil_rready_in(rready), .frame_lock_err_in(fle),
    .local_coef_in(coef), .an_master_lane_out(lane),
    .restart_training_out(rst_p), .partner_coef_new_out(tx_p),
    .local_coef_new_out(rx_p), .local_coef_out(), .irq_out(irq)
  );
  klt_partner u_lane (
    .clock_in(clk), .rstn_in(rstn), .restart_in(rst_p), .tx_new_in(tx_p),
    .rx_new_in(rx_p), .fle_in(fle_set), .clr_in(clr), .fle_out(fle),
    .coef_out(coef), .seen_out(seen)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(logic [9:0] i, logic [31:0] d, logic [3:0] s,
                    logic [1:0] x);
    bit ad, wd;
    qb.push_back(x);
    @(posedge clk);
    awaddr <= {i, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(logic [9:0] i, logic [31:0] d, logic [1:0] x);
    qr.push_back({x, d});
    @(posedge clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
  endtask
  // Command write, then the log of pulses seen on the lane side
  task automatic cmd(logic [31:0] d, logic [3:0] s, logic [8:0] x);
    wr(IDX_LANE_TRAINING_COMMANDS, d, s, RESP_OKAY);
    @(posedge clk);
    chk("pulses", 32'(seen), 32'(x));
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic lane_is(logic [9:0] i, logic [31:0] d, logic [3:0] x);
    wr(i, d, 4'hf, RESP_OKAY);
    @(posedge clk);
    chk("lane", 32'(lane), 32'(x));
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (bvalid && bready) begin
      chk("bresp", 32'(bresp), 32'(qb.pop_front()));
    end
    if (rvalid && rready) begin
      e = qr.pop_front();
      chk("rdata", rdata, e[31:0]);
      chk("rresp", 32'(rresp), 32'(e[33:32]));
    end
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, clr} = 7'h0;
    {awaddr, araddr, wdata, wstrb, fle_set} = '0;
    r = $urandom(32'hdce2813a);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(IDX_AN_OVERRIDE, 32'h0, RESP_OKAY);
    rd(IDX_AN_MASTER_LANE_SELECT, 32'h0, RESP_OKAY);
    rd(10'h001, 32'h0, RESP_SLVERR);
    wr(10'h001, 32'hffffffff, 4'hf, RESP_SLVERR);
    lane_is(IDX_AN_MASTER_LANE_SELECT, 32'h8, 4'h1);
    lane_is(IDX_AN_OVERRIDE, 32'h40, 4'h8);
    for (int i = 0; i < 4; i++) begin
      lane_is(IDX_AN_MASTER_LANE_SELECT, 32'h1 << i, 4'h1 << i);
    end
    lane_is(IDX_AN_OVERRIDE, 32'h0, 4'h1);
    for (int k = 0; k < 8; k++) begin
      r = $urandom();
      cmd(r, 4'hf, {6'h0, r[3:1]});
    end
    rd(IDX_LANE_TRAINING_COMMANDS, 32'h0, RESP_OKAY);
    wr(IDX_COEF_OVERRIDE, 32'h30000, 4'hf, RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      r = $urandom();
      cmd(r, 4'hf, {r[11:9], r[7:5], r[3:1]});
    end
    cmd(32'hfff, 4'h2, 9'h1c0);
    wr(IDX_COEF_OVERRIDE, 32'h10000, 4'h4, RESP_OKAY);
    cmd(32'hfff, 4'hf, 9'h03f);
    // Lane 1 error rises: sticky status, masked then unmasked
    fle_set <= 32'h100;
    repeat (4) @(posedge clk);
    rd(IDX_IRQ_STATUS, 32'h2, RESP_OKAY);
    chk("irq", 32'(irq), 32'h0);
    wr(IDX_IRQ_MASK, 32'h2, 4'hf, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", 32'(irq), 32'h1);
    wr(IDX_IRQ_STATUS, 32'h2, 4'hf, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", 32'(irq), 32'h0);
    rd(IDX_IRQ_STATUS, 32'h0, RESP_OKAY);
    r = $urandom();
    fle_set <= r;
    repeat (4) @(posedge clk);
    rd(IDX_FRAME_LOCK_ERROR_STATUS, r, RESP_OKAY);
    wr(IDX_FRAME_LOCK_ERROR_STATUS, ~r, 4'hf, RESP_OKAY);
    rd(IDX_FRAME_LOCK_ERROR_STATUS, r, RESP_OKAY);
    end_sim();
  end
endmodule
`default_nettype wire
